/* design/window_compare_limit_regs.sv */
// Purpose: limit, hysteresis and run-length bank with its comparators
// Assumes: classic wishbone master, samples from logic on core_clk
// Notes: one cycle wait state on every access, unmapped reads give zero
`timescale 1ns/10ps
`default_nettype none
module window_compare_limit_regs
    import wcl_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire wcl_pkg::wb_req_t wb_req,
    output wcl_pkg::wb_rsp_t wb_rsp,
    input wire wcl_pkg::sample_t ch2_sample,
    input wire wcl_pkg::sample_t ch3_sample,
    input wire logic [7:0] ch3_lower_limit_high_byte,
    output logic [1:0] chan_alert
);
    import wcl_pkg::*;

    typedef struct packed {
        bus_state_t bus;
        logic ack;
        logic [DAT_W-1:0] rdata;
        logic [REG_W-1:0] ch1_low_limit_upper;
        logic [REG_W-1:0] ch2_hyst_and_high_lower;
        logic [REG_W-1:0] ch2_high_limit_upper;
        logic [REG_W-1:0] ch2_count_and_low_lower;
        logic [REG_W-1:0] ch2_low_limit_upper;
        logic [REG_W-1:0] ch3_hyst_and_high_lower;
        logic [REG_W-1:0] ch3_high_limit_upper;
        logic [REG_W-1:0] ch3_count_and_low_lower;
    } bank_st_t;

    bank_st_t s_r;
    bank_st_t s_nxt;
    logic rst_n_sync;
    logic [IDX_W-1:0] idx;
    logic req;
    logic wr_en;
    logic [REG_W-1:0] wbyte;
    logic [REG_W-1:0] rbyte;
    logic hit_idx;
    ch_cfg_t cfg [NUM_CH];
    sample_t smp [NUM_CH];
    logic [NUM_CH-1:0] alert_w;
    logic [NUM_CH-1:0] hit_w;

    wcl_reset_sync u_rst (
        .core_clk(core_clk),
        .resetn(resetn),
        .rst_n_sync(rst_n_sync)
    );

    // channel 3 low byte lives outside this bank and arrives as a port
    always_comb begin
        cfg[0].hyst_reg = s_r.ch2_hyst_and_high_lower;
        cfg[0].high_up = s_r.ch2_high_limit_upper;
        cfg[0].count_reg = s_r.ch2_count_and_low_lower;
        cfg[0].low_up = s_r.ch2_low_limit_upper;
        cfg[1].hyst_reg = s_r.ch3_hyst_and_high_lower;
        cfg[1].high_up = s_r.ch3_high_limit_upper;
        cfg[1].count_reg = s_r.ch3_count_and_low_lower;
        cfg[1].low_up = ch3_lower_limit_high_byte;
        smp[0] = ch2_sample;
        smp[1] = ch3_sample;
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            wcl_channel u_ch (
                .core_clk(core_clk),
                .rst_n(rst_n_sync),
                .cfg(cfg[gi]),
                .smp(smp[gi]),
                .alert(alert_w[gi]),
                .hit(hit_w[gi])
            );
        end
    endgenerate

    // word index from the byte address, low two bits ignored
    always_comb begin
        idx = wb_req.adr[ADR_LSB +: IDX_W];
        req = wb_req.cyc & wb_req.stb;
        wr_en = req & wb_req.we & wb_req.sel[0];
        wbyte = wb_req.dat[REG_W-1:0];
    end

    // read decode, consecutive indexes per channel
    always_comb begin
        rbyte = '0;
        hit_idx = 1'b1;
        case (idx)
            IDX_CH1_LOW_UP: begin
                rbyte = s_r.ch1_low_limit_upper;
            end
            IDX_CH2_HYST: begin
                rbyte = s_r.ch2_hyst_and_high_lower;
            end
            IDX_CH2_HIGH_UP: begin
                rbyte = s_r.ch2_high_limit_upper;
            end
            IDX_CH2_COUNT: begin
                rbyte = s_r.ch2_count_and_low_lower;
            end
            IDX_CH2_LOW_UP: begin
                rbyte = s_r.ch2_low_limit_upper;
            end
            IDX_CH3_HYST: begin
                rbyte = s_r.ch3_hyst_and_high_lower;
            end
            IDX_CH3_HIGH_UP: begin
                rbyte = s_r.ch3_high_limit_upper;
            end
            IDX_CH3_COUNT: begin
                rbyte = s_r.ch3_count_and_low_lower;
            end
            IDX_STATUS: begin
                rbyte = {4'h0, hit_w, alert_w};
            end
            default: begin
                hit_idx = 1'b0;
            end
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.ack = 1'b0;
        case (s_r.bus)
            BUS_IDLE: begin
                // ack lands one edge after the request is seen
                if (req) begin
                    s_nxt.bus = BUS_ACK;
                    s_nxt.ack = 1'b1;
                    s_nxt.rdata = '0;
                    if (hit_idx) begin
                        s_nxt.rdata = {24'h000000, rbyte};
                    end
                end
            end
            BUS_ACK: begin
                // write commits on the ack edge, the only one master samples
                s_nxt.bus = BUS_IDLE;
                if (wr_en) begin
                    case (idx)
                        IDX_CH1_LOW_UP: begin
                            s_nxt.ch1_low_limit_upper = wbyte;
                        end
                        IDX_CH2_HYST: begin
                            s_nxt.ch2_hyst_and_high_lower = wbyte;
                        end
                        IDX_CH2_HIGH_UP: begin
                            s_nxt.ch2_high_limit_upper = wbyte;
                        end
                        IDX_CH2_COUNT: begin
                            s_nxt.ch2_count_and_low_lower = wbyte;
                        end
                        IDX_CH2_LOW_UP: begin
                            s_nxt.ch2_low_limit_upper = wbyte;
                        end
                        IDX_CH3_HYST: begin
                            s_nxt.ch3_hyst_and_high_lower = wbyte;
                        end
                        IDX_CH3_HIGH_UP: begin
                            s_nxt.ch3_high_limit_upper = wbyte;
                        end
                        IDX_CH3_COUNT: begin
                            s_nxt.ch3_count_and_low_lower = wbyte;
                        end
                        default: begin
                            s_nxt.bus = BUS_IDLE;
                        end
                    endcase
                end
            end
            default: begin
                s_nxt.bus = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            s_r.bus <= BUS_IDLE;
            s_r.ack <= 1'b0;
            s_r.rdata <= '0;
            s_r.ch1_low_limit_upper <= RST_LOW_UP;
            s_r.ch2_hyst_and_high_lower <= RST_HYST;
            s_r.ch2_high_limit_upper <= RST_HIGH_UP;
            s_r.ch2_count_and_low_lower <= RST_COUNT;
            s_r.ch2_low_limit_upper <= RST_LOW_UP;
            s_r.ch3_hyst_and_high_lower <= RST_HYST;
            s_r.ch3_high_limit_upper <= RST_HIGH_UP;
            s_r.ch3_count_and_low_lower <= RST_COUNT;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_comb begin
        wb_rsp.ack = s_r.ack;
        wb_rsp.dat = s_r.rdata;
        chan_alert = alert_w;
    end
endmodule
`default_nettype wire

/* design/wcl_pkg.sv */
// Purpose: shared constants and carriers for the window limit bank
// Assumes: 8-bit registers on a 32-bit classic wishbone bus
// Notes: register indexes are word indexes, byte address = index * 4
package wcl_pkg;
    localparam int unsigned ADR_W = 10;
    localparam int unsigned DAT_W = 32;
    localparam int unsigned REG_W = 8;
    localparam int unsigned RES_W = 12;
    localparam int unsigned NIB_W = 4;
    localparam int unsigned IDX_W = 8;
    localparam int unsigned HYS_W = 7;
    localparam int unsigned RUN_W = 5;
    localparam int unsigned NUM_CH = 2;

    localparam logic [IDX_W-1:0] IDX_CH1_LOW_UP = 8'h27;
    localparam logic [IDX_W-1:0] IDX_CH2_HYST = 8'h28;
    localparam logic [IDX_W-1:0] IDX_CH2_HIGH_UP = 8'h29;
    localparam logic [IDX_W-1:0] IDX_CH2_COUNT = 8'h2A;
    localparam logic [IDX_W-1:0] IDX_CH2_LOW_UP = 8'h2B;
    localparam logic [IDX_W-1:0] IDX_CH3_HYST = 8'h2C;
    localparam logic [IDX_W-1:0] IDX_CH3_HIGH_UP = 8'h2D;
    localparam logic [IDX_W-1:0] IDX_CH3_COUNT = 8'h2E;
    localparam logic [IDX_W-1:0] IDX_STATUS = 8'h40;

    localparam logic [REG_W-1:0] RST_HYST = 8'hF0;
    localparam logic [REG_W-1:0] RST_HIGH_UP = 8'hFF;
    localparam logic [REG_W-1:0] RST_COUNT = 8'h00;
    localparam logic [REG_W-1:0] RST_LOW_UP = 8'h00;

    // upper nibble holds the limit low bits, lower nibble hyst or count
    localparam int unsigned NIB_HI_LSB = 4;
    localparam int unsigned NIB_LO_LSB = 0;
    localparam int unsigned HYS_SHIFT = 3;
    localparam int unsigned ADR_LSB = 2;
    localparam int unsigned STAT_HIT_LSB = 2;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [ADR_W-1:0] adr;
        logic [DAT_W-1:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic ack;
        logic [DAT_W-1:0] dat;
    } wb_rsp_t;

    typedef struct packed {
        logic [REG_W-1:0] hyst_reg;
        logic [REG_W-1:0] high_up;
        logic [REG_W-1:0] count_reg;
        logic [REG_W-1:0] low_up;
    } ch_cfg_t;

    typedef struct packed {
        logic valid;
        logic [RES_W-1:0] result;
    } sample_t;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } bus_state_t;
endpackage

/* design/wcl_reset_sync.sv */
// Purpose: release of the active low reset through two flip-flops
// Assumes: resetn may arrive at any time
// Notes: assertion is immediate, release takes two edges
`timescale 1ns/10ps
`default_nettype none
module wcl_reset_sync (
    input wire logic core_clk,
    input wire logic resetn,
    output logic rst_n_sync
);
    typedef struct packed {
        logic stage1;
        logic stage2;
    } sync_st_t;

    sync_st_t s_r;
    sync_st_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.stage1 = 1'b1;
        s_nxt.stage2 = s_r.stage1;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rst_n_sync = s_r.stage2;
endmodule
`default_nettype wire

/* design/wcl_channel.sv */
// Purpose: window compare and run counter for one channel
// Assumes: sample strobe and result come from logic on core_clk
// Notes: hysteresis relaxes both limits only while the alert stands
`timescale 1ns/10ps
`default_nettype none
module wcl_channel
    import wcl_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire wcl_pkg::ch_cfg_t cfg,
    input wire wcl_pkg::sample_t smp,
    output logic alert,
    output logic hit
);
    typedef struct packed {
        logic [RUN_W-1:0] run;
        logic alert;
        logic hit;
    } ch_st_t;

    ch_st_t s_r;
    ch_st_t s_nxt;
    logic [RES_W-1:0] high_lim;
    logic [RES_W-1:0] low_lim;
    logic [HYS_W-1:0] hyst;
    logic [NIB_W-1:0] need;
    logic [RES_W:0] high_rel;
    logic [RES_W:0] low_rel;
    logic above;
    logic below;
    logic exceed;

    always_comb begin
        high_lim = {cfg.high_up, cfg.hyst_reg[REG_W-1:NIB_HI_LSB]};
        low_lim = {cfg.low_up, cfg.count_reg[REG_W-1:NIB_HI_LSB]};
        hyst = {cfg.hyst_reg[NIB_W-1:NIB_LO_LSB], 3'h0};
        need = cfg.count_reg[NIB_W-1:NIB_LO_LSB];
        // widened by one bit so the relaxed limits cannot wrap
        high_rel = {1'b0, high_lim} - {6'h00, hyst};
        low_rel = {1'b0, low_lim} + {6'h00, hyst};
        if (high_rel[RES_W]) begin
            high_rel = '0;
        end
        // full 12-bit compare covers top byte and low nibble together
        if (s_r.alert) begin
            above = {1'b0, smp.result} > high_rel;
            below = {1'b0, smp.result} < low_rel;
        end else begin
            above = smp.result > high_lim;
            below = smp.result < low_lim;
        end
        exceed = above | below;
        s_nxt = s_r;
        if (smp.valid) begin
            s_nxt.hit = exceed;
            if (exceed) begin
                if (s_r.run <= {1'b0, need}) begin
                    s_nxt.run = s_r.run + 5'h01;
                end
                if (s_r.run >= {1'b0, need}) begin
                    s_nxt.alert = 1'b1;
                end
            end else begin
                s_nxt.run = '0;
                s_nxt.alert = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign alert = s_r.alert;
    assign hit = s_r.hit;
endmodule
`default_nettype wire

/* bench/window_compare_limit_regs_assertions.sv */
// Purpose: port checker for the window limit bank
// Assumes: one clock domain, sees only the top ports
// Notes: limit contents are hidden here, so checks lean on the bus
`timescale 1ns/10ps
`default_nettype none
module window_compare_limit_regs_assertions
    import wcl_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire wcl_pkg::wb_req_t wb_req,
    input wire wcl_pkg::wb_rsp_t wb_rsp,
    input wire wcl_pkg::sample_t ch2_sample,
    input wire wcl_pkg::sample_t ch3_sample,
    input wire logic [7:0] ch3_lower_limit_high_byte,
    input wire logic [1:0] chan_alert
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    chk_ack_one_wait: assert property (
        $rose(wb_req.cyc && wb_req.stb) |=> wb_rsp.ack)
        else $error("ack not one cycle after request");
    chk_ack_single: assert property (
        wb_rsp.ack |=> !wb_rsp.ack)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property (
        wb_rsp.ack |-> $past(wb_req.cyc && wb_req.stb))
        else $error("ack without request");
    chk_byte_wide: assert property (
        wb_rsp.ack |-> wb_rsp.dat[31:8] == 24'h0)
        else $error("read data above bit 7 not zero");
    chk_ch2_hold: assert property (
        !ch2_sample.valid |=> $stable(chan_alert[0]))
        else $error("ch2 alert moved without sample");
    chk_ch3_hold: assert property (
        !ch3_sample.valid |=> $stable(chan_alert[1]))
        else $error("ch3 alert moved without sample");
    chk_ch3_below: assert property (
        ch3_sample.valid && chan_alert[1]
        && ch3_sample.result[11:4] < ch3_lower_limit_high_byte
        |=> chan_alert[1])
        else $error("ch3 alert cleared below low limit");
    chk_alert_reset: assert property (
        $rose(resetn) |-> chan_alert == 2'b00 ##1 chan_alert == 2'b00)
        else $error("alert set out of reset");
endmodule
bind window_compare_limit_regs window_compare_limit_regs_assertions
    window_compare_limit_regs_assertions_i (.core_clk(core_clk),
    .resetn(resetn), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .ch2_sample(ch2_sample), .ch3_sample(ch3_sample),
    .ch3_lower_limit_high_byte(ch3_lower_limit_high_byte),
    .chan_alert(chan_alert));
`default_nettype wire

/* bench/window_compare_limit_regs_tb_top.sv */
// Purpose: directed bench for the window limit bank
// Assumes: byte address is word index times four
// Notes: ch3 low limit byte is a port, so the bench drives it
`timescale 1ns/10ps
`default_nettype none
module window_compare_limit_regs_tb_top;
    import wcl_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    wb_req_t req = '0;
    wb_rsp_t rsp;
    sample_t s2 = '0;
    sample_t s3 = '0;
    logic [7:0] lo3 = 8'h20;
    logic [1:0] alert;
    logic [31:0] rd;
    int mismatches = 0;
    int num_checks = 0;
    logic [7:0] idx_tab [8] = '{IDX_CH1_LOW_UP, IDX_CH2_HYST,
        IDX_CH2_HIGH_UP, IDX_CH2_COUNT, IDX_CH2_LOW_UP, IDX_CH3_HYST,
        IDX_CH3_HIGH_UP, IDX_CH3_COUNT};
    logic [7:0] rst_tab [8] = '{RST_LOW_UP, RST_HYST, RST_HIGH_UP,
        RST_COUNT, RST_LOW_UP, RST_HYST, RST_HIGH_UP, RST_COUNT};

    always #25 core_clk = ~core_clk;

    window_compare_limit_regs window_compare_limit_regs_i (
        .core_clk(core_clk), .resetn(resetn), .wb_req(req),
        .wb_rsp(rsp), .ch2_sample(s2), .ch3_sample(s3),
        .ch3_lower_limit_high_byte(lo3), .chan_alert(alert));

    task automatic chk(input string what, input logic [31:0] got,
            input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] idx,
            input logic [7:0] wd, input logic s0);
        int n;
        n = 0;
        @(posedge core_clk);
        req <= '{1'b1, 1'b1, wr, {3'b111, s0}, {idx, 2'b00}, {24'h0, wd}};
        do begin
            @(posedge core_clk);
            n++;
        end while (rsp.ack !== 1'b1 && n < 50);
        if (n >= 50) mismatches++;
        rd = rsp.dat;
        req <= '0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        bus(1'b1, idx, wd, 1'b1);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00, 1'b1);
        chk($sformatf("reg %h", idx), rd, {24'h0, exp});
    endtask

    // valid is a one-cycle strobe; alert is judged once that edge landed
    task automatic smp(input logic ch3, input logic [11:0] r,
            input logic [1:0] exp);
        @(posedge core_clk);
        if (ch3) s3 <= '{1'b1, r};
        else s2 <= '{1'b1, r};
        @(posedge core_clk);
        s2.valid <= 1'b0;
        s3.valid <= 1'b0;
        @(negedge core_clk);
        chk($sformatf("alert after %h", r), {30'h0, alert}, {30'h0, exp});
    endtask

    task automatic do_reset();
        @(posedge core_clk);
        resetn <= 1'b0;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask

    task automatic t_reset_vals();
        chk("alert after reset", {30'h0, alert}, 32'h0);
        for (int i = 0; i < 8; i++) begin
            rdc(idx_tab[i], rst_tab[i]);
        end
    endtask

    task automatic t_map();
        for (int i = 0; i < 8; i++) wr(idx_tab[i], 8'((i + 1) * 17));
        for (int i = 0; i < 8; i++) begin
            rdc(idx_tab[i], 8'((i + 1) * 17));
        end
        wr(8'h30, 8'h5A);
        rdc(8'h30, 8'h00);
        bus(1'b1, IDX_CH2_HIGH_UP, 8'h5A, 1'b0);
        rdc(IDX_CH2_HIGH_UP, 8'h33);
    endtask

    // high limit 805, run of three needed, then hysteresis of 8
    task automatic t_ch2_high();
        wr(IDX_CH2_HYST, 8'h50);
        wr(IDX_CH2_HIGH_UP, 8'h80);
        wr(IDX_CH2_COUNT, 8'h02);
        wr(IDX_CH2_LOW_UP, 8'h00);
        smp(1'b0, 12'h805, 2'b00);
        smp(1'b0, 12'h806, 2'b00);
        smp(1'b0, 12'h806, 2'b00);
        smp(1'b0, 12'h800, 2'b00);
        smp(1'b0, 12'h806, 2'b00);
        smp(1'b0, 12'h806, 2'b00);
        smp(1'b0, 12'h806, 2'b01);
        wr(IDX_CH2_HYST, 8'h51);
        smp(1'b0, 12'h7FE, 2'b01);
        smp(1'b0, 12'h7FD, 2'b00);
    endtask

    // low limit 403 with no run length; ch3 low byte from its port
    task automatic t_low();
        wr(IDX_CH2_LOW_UP, 8'h40);
        wr(IDX_CH2_COUNT, 8'h30);
        smp(1'b0, 12'h403, 2'b00);
        smp(1'b0, 12'h402, 2'b01);
        smp(1'b0, 12'h40A, 2'b01);
        smp(1'b0, 12'h40B, 2'b00);
        wr(IDX_CH3_HYST, 8'hF0);
        wr(IDX_CH3_HIGH_UP, 8'hFF);
        wr(IDX_CH3_COUNT, 8'h00);
        smp(1'b1, 12'h1FF, 2'b10);
        smp(1'b1, 12'h1F0, 2'b10);
        rdc(IDX_STATUS, 8'h0A);
        wr(IDX_STATUS, 8'hFF);
        rdc(IDX_STATUS, 8'h0A);
        smp(1'b1, 12'h200, 2'b00);
        // move the external low byte; the alert is left set for the reset
        @(posedge core_clk);
        lo3 <= 8'h30;
        smp(1'b1, 12'h2FF, 2'b10);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        do_reset();
        t_reset_vals();
        t_map();
        t_ch2_high();
        t_low();
        do_reset();
        t_reset_vals();
        results();
    end

    initial begin
        repeat (5000) @(posedge core_clk);
        mismatches++;
        results();
    end
endmodule
`default_nettype wire
